/* File: rtl/kmc_pkg.sv */
// shared constants and types for the keypad menu controller
package kmc_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned CONFIRM_TIME_MS  = 1000;
  localparam int unsigned CONFIRM_CYCLES   = CONFIRM_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_HALF_MS    = 250;
  localparam int unsigned FLASH_CYCLES     = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W            = 26;

  localparam int unsigned PARAM_COUNT      = 16;
  localparam int unsigned PNUM_W           = 4;
  localparam int unsigned DATA_W           = 16;
  localparam int unsigned ITEM_COUNT       = 7;
  localparam int unsigned ADR_W            = 8;

  // wishbone register byte addresses
  localparam logic [7:0] STATUS_ADR        = 8'h00;
  localparam logic [7:0] CONTROL_ADR       = 8'h04;
  localparam logic [7:0] LOCK_MASK_ADR     = 8'h08;
  localparam logic [7:0] PARAM_SEL_ADR     = 8'h0c;
  localparam logic [7:0] PARAM_DATA_ADR    = 8'h10;

  // status and control field positions
  localparam int unsigned ST_ITEM_LSB      = 0;
  localparam int unsigned ST_PROG_LSB      = 4;
  localparam int unsigned ST_REVERSE_BIT   = 8;
  localparam int unsigned ST_LOCAL_BIT     = 9;
  localparam int unsigned ST_INHIBIT_BIT   = 10;
  localparam int unsigned ST_RUN_BIT       = 11;
  localparam int unsigned ST_RUNNING_BIT   = 12;
  localparam int unsigned ST_PNUM_LSB      = 16;
  localparam int unsigned CTL_TERMINAL_BIT = 0;

  // reset values
  localparam logic [15:0] LOCK_MASK_RST    = 16'h0000;
  localparam logic [15:0] PARAM_RST        = 16'h0000;
  localparam logic        CONTROL_RST      = 1'b0;

  // display glyph codes, values are arbitrary encodings
  localparam logic [15:0] FORWARD_CODE     = 16'hf0f0;
  localparam logic [15:0] REVERSE_CODE     = 16'hf0e0;
  localparam logic [15:0] REMOTE_CODE      = 16'he0e0;
  localparam logic [15:0] LOCAL_CODE       = 16'he0d0;
  localparam logic [11:0] PNUM_PREFIX      = 12'hd00;

  typedef enum logic [2:0] {
    frequency_reference_item,
    output_frequency_item,
    output_current_item,
    monitor_item,
    direction_item,
    control_source_item,
    programming_item
  } kmc_item_t;

  typedef enum logic [1:0] {
    PROG_NUMBER,
    PROG_VALUE,
    PROG_EDIT,
    PROG_CONFIRM
  } kmc_prog_t;
endpackage

/* File: rtl/kmc_key_sync.sv */
// two-flop synchroniser with rising-edge press pulse for one pin
`timescale 1ns/1ns
module kmc_key_sync (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      press_out
);
  logic meta;
  logic last;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta      <= 1'b0;
      level_out <= 1'b0;
      last      <= 1'b0;
    end else begin
      meta      <= pin_in;
      level_out <= meta;
      last      <= level_out;
    end
  end

  assign press_out = level_out & ~last;
endmodule

/* File: rtl/kmc_menu.sv */
// keypad menu controller: item selection, direction, control source, parameter edit
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module kmc_menu #(
  parameter int unsigned CONFIRM_CNT = kmc_pkg::CONFIRM_CYCLES,
  parameter int unsigned FLASH_CNT   = kmc_pkg::FLASH_CYCLES
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic                        key_mode_in,
  input  wire logic                        key_inc_in,
  input  wire logic                        key_dec_in,
  input  wire logic                        key_enter_in,
  input  wire logic                        run_request_in,
  input  wire logic                        drive_running_in,
  input  wire logic                        terminal_local_in,
  input  wire logic [kmc_pkg::DATA_W-1:0]  monitor_value_in,
  input  wire logic                        wb_cyc_in,
  input  wire logic                        wb_stb_in,
  input  wire logic                        wb_we_in,
  input  wire logic [kmc_pkg::ADR_W-1:0]   wb_adr_in,
  input  wire logic [31:0]                 wb_dat_in,
  input  wire logic [3:0]                  wb_sel_in,
  output logic [31:0]                      wb_dat_out,
  output logic                             wb_ack_out,
  output logic [kmc_pkg::ITEM_COUNT-1:0]   indicator_out,
  output logic [kmc_pkg::DATA_W-1:0]       display_data_out,
  output logic                             display_lit_out,
  output logic                             reverse_out,
  output logic                             control_local_out,
  output logic                             run_command_out
);
  import kmc_pkg::*;

  // byte-lane merge of a 16-bit register with a wishbone write
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic kmc_item_t next_menu(input kmc_item_t cur);
    next_menu = (cur == programming_item) ? frequency_reference_item : kmc_item_t'(cur + 3'd1);
  endfunction

  logic mode_press, inc_press, dec_press, enter_press;
  logic run_level, running, term_level;

  kmc_key_sync u_mode  (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(key_mode_in),
                        .level_out(), .press_out(mode_press));
  kmc_key_sync u_inc   (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(key_inc_in),
                        .level_out(), .press_out(inc_press));
  kmc_key_sync u_dec   (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(key_dec_in),
                        .level_out(), .press_out(dec_press));
  kmc_key_sync u_enter (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(key_enter_in),
                        .level_out(), .press_out(enter_press));
  kmc_key_sync u_run   (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(run_request_in),
                        .level_out(run_level), .press_out());
  kmc_key_sync u_drv   (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(drive_running_in),
                        .level_out(running), .press_out());
  kmc_key_sync u_term  (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .pin_in(terminal_local_in),
                        .level_out(term_level), .press_out());

  kmc_item_t               item;
  kmc_item_t               next_item;
  kmc_prog_t               prog;
  kmc_prog_t               next_prog;
  logic [PNUM_W-1:0]       param_num;
  logic [PNUM_W-1:0]       next_param_num;
  logic [DATA_W-1:0]       edit_value;
  logic [DATA_W-1:0]       next_edit_value;
  logic                    reverse;
  logic                    next_reverse;
  logic                    local_sel;
  logic                    next_local_sel;
  logic                    store;
  logic                    inhibit;
  logic                    next_inhibit;
  logic [DATA_W-1:0]       params [PARAM_COUNT];
  logic [DATA_W-1:0]       lock_mask;
  logic                    terminal_assign;
  logic [PNUM_W-1:0]       bus_sel;
  logic [CNT_W-1:0]        confirm_cnt;
  logic [CNT_W-1:0]        flash_cnt;
  logic                    blink;
  logic [DATA_W-1:0]       next_display;

  // a simultaneous Increment and Decrement cancel out
  wire        step        = inc_press ^ dec_press;
  wire        step_up     = inc_press;
  wire        confirm_end = (prog == PROG_CONFIRM) && (confirm_cnt == CNT_W'(CONFIRM_CNT - 1));
  wire        flash_end   = (flash_cnt == CNT_W'(FLASH_CNT - 1));
  wire        locked_now  = lock_mask[param_num] & running;
  wire        inhibit_zone = (item == control_source_item) || (item == programming_item);
  wire        green_item  = (item == frequency_reference_item) || (item == output_frequency_item) ||
                            (item == output_current_item) || (item == monitor_item);

  wire        bus_req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // writes land on the edge that samples ack high, while the master still holds the request
  wire        bus_wr      = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
  wire        wr_control  = bus_wr && (wb_adr_in == CONTROL_ADR);
  wire        wr_lock     = bus_wr && (wb_adr_in == LOCK_MASK_ADR);
  wire        wr_sel      = bus_wr && (wb_adr_in == PARAM_SEL_ADR);
  wire        wr_data     = bus_wr && (wb_adr_in == PARAM_DATA_ADR) && !store;
  wire [PNUM_W-1:0] wr_index = store ? param_num : bus_sel;
  wire [DATA_W-1:0] wr_value = store ? edit_value : lane_merge(params[bus_sel], wb_dat_in, wb_sel_in);
  wire        param_we    = store | wr_data;

  wire [31:0] status_word = {12'h000, param_num, 3'b000, running, run_command_out, inhibit, local_sel, reverse,
                             2'b00, prog, 1'b0, item};
  wire [31:0] read_word   = (wb_adr_in == STATUS_ADR)     ? status_word :
                            (wb_adr_in == CONTROL_ADR)    ? {31'h0, terminal_assign} :
                            (wb_adr_in == LOCK_MASK_ADR)  ? {16'h0000, lock_mask} :
                            (wb_adr_in == PARAM_SEL_ADR)  ? {28'h0000000, bus_sel} :
                            (wb_adr_in == PARAM_DATA_ADR) ? {16'h0000, params[bus_sel]} : 32'h0;

  // keypad interpretation
  always_comb begin
    next_item       = item;
    next_prog       = prog;
    next_param_num  = param_num;
    next_edit_value = edit_value;
    next_reverse    = reverse;
    next_local_sel  = local_sel;
    store           = 1'b0;
    if (confirm_end) begin
      next_prog = PROG_NUMBER;
    end
    if (mode_press) begin
      if (item == programming_item && prog != PROG_NUMBER) begin
        next_prog = PROG_NUMBER;
      end else begin
        next_item = next_menu(item);
        next_prog = PROG_NUMBER;
      end
    end else if (enter_press && item == programming_item) begin
      unique case (prog)
        PROG_NUMBER: begin
          next_prog       = PROG_VALUE;
          next_edit_value = params[param_num];
        end
        PROG_EDIT: begin
          store     = 1'b1;
          next_prog = PROG_CONFIRM;
        end
        PROG_VALUE, PROG_CONFIRM: begin
          next_prog = prog;
        end
      endcase
    end else if (step) begin
      unique case (item)
        direction_item: begin
          next_reverse = ~reverse;
        end
        control_source_item: begin
          if (!running && !terminal_assign) begin
            next_local_sel = ~local_sel;
          end
        end
        programming_item: begin
          if (prog == PROG_NUMBER) begin
            next_param_num = step_up ? param_num + 4'h1 : param_num - 4'h1;
          end else if (prog != PROG_CONFIRM && !locked_now) begin
            next_edit_value = step_up ? edit_value + 16'h0001 : edit_value - 16'h0001;
            next_prog       = PROG_EDIT;
          end
        end
        default: begin
          next_reverse = reverse;
        end
      endcase
    end
    if (terminal_assign) begin
      next_local_sel = term_level;
    end
  end

  // inhibit latches in the inhibit items and only clears with RUN low on a green item
  always_comb begin
    next_inhibit = inhibit;
    if (inhibit_zone) begin
      next_inhibit = 1'b1;
    end else if (green_item && !run_level) begin
      next_inhibit = 1'b0;
    end
  end

  // display follows the next state so it changes on the same edge as the setting
  always_comb begin
    unique case (next_item)
      frequency_reference_item: next_display = params[0];
      direction_item:           next_display = next_reverse ? REVERSE_CODE : FORWARD_CODE;
      control_source_item:      next_display = next_local_sel ? LOCAL_CODE : REMOTE_CODE;
      programming_item: begin
        unique case (next_prog)
          PROG_NUMBER:  next_display = {PNUM_PREFIX, next_param_num};
          default:      next_display = next_edit_value;
        endcase
      end
      default:                  next_display = monitor_value_in;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      item       <= frequency_reference_item;
      prog       <= PROG_NUMBER;
      param_num  <= '0;
      edit_value <= '0;
      reverse    <= 1'b0;
      local_sel  <= 1'b0;
      inhibit    <= 1'b0;
    end else begin
      item       <= next_item;
      prog       <= next_prog;
      param_num  <= next_param_num;
      edit_value <= next_edit_value;
      reverse    <= next_reverse;
      local_sel  <= next_local_sel;
      inhibit    <= next_inhibit;
    end
  end

  // confirm hold and flash phase timers
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      confirm_cnt <= '0;
      flash_cnt   <= '0;
      blink       <= 1'b1;
    end else begin
      confirm_cnt <= (next_prog == PROG_CONFIRM && prog == PROG_CONFIRM) ? confirm_cnt + 26'h1 : '0;
      flash_cnt   <= (next_prog != PROG_EDIT || flash_end) ? '0 : flash_cnt + 26'h1;
      blink       <= (next_prog != PROG_EDIT) ? 1'b1 : (flash_end ? ~blink : blink);
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        params[i] <= PARAM_RST;
      end
    end else if (param_we) begin
      params[wr_index] <= wr_value;
    end
  end

  // software registers
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      terminal_assign <= CONTROL_RST;
      lock_mask       <= LOCK_MASK_RST;
      bus_sel         <= '0;
      wb_ack_out      <= 1'b0;
      wb_dat_out      <= 32'h0;
    end else begin
      if (wr_control && wb_sel_in[0]) begin
        terminal_assign <= wb_dat_in[CTL_TERMINAL_BIT];
      end
      if (wr_lock) begin
        lock_mask <= lane_merge(lock_mask, wb_dat_in, wb_sel_in);
      end
      if (wr_sel && wb_sel_in[0]) begin
        bus_sel <= wb_dat_in[PNUM_W-1:0];
      end
      wb_ack_out <= bus_req;
      wb_dat_out <= (bus_req && !wb_we_in) ? read_word : 32'h0;
    end
  end

  // outputs
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      indicator_out     <= 7'h01;
      display_data_out  <= PARAM_RST;
      display_lit_out   <= 1'b1;
      reverse_out       <= 1'b0;
      control_local_out <= 1'b0;
      run_command_out   <= 1'b0;
    end else begin
      indicator_out     <= 7'h01 << next_item;
      display_data_out  <= next_display;
      display_lit_out   <= (next_prog != PROG_EDIT) || (flash_end ? ~blink : blink);
      reverse_out       <= next_reverse;
      control_local_out <= next_local_sel;
      run_command_out   <= run_level && !next_inhibit && !(next_item == control_source_item) &&
                           !(next_item == programming_item);
    end
  end
endmodule

/* File: bench/kmc_sva.sv */
// port-level concurrent checks for the keypad menu controller
`timescale 1ns/1ns
module kmc_sva
  import kmc_pkg::*;
#(
  parameter int unsigned CONFIRM_CNT = 20,
  parameter int unsigned FLASH_CNT   = 4
) (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [6:0]  indicator_out,
  input wire logic [15:0] display_data_out,
  input wire logic        display_lit_out,
  input wire logic        reverse_out,
  input wire logic        control_local_out,
  input wire logic        run_command_out
);
  wire logic [6:0] ind_rot = {indicator_out[5:0], indicator_out[6]};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [31:0] dark_len;
  // samples spent dark so far in the current flash phase
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dark_len <= 32'h0;
    end else begin
      dark_len <= display_lit_out ? 32'h0 : dark_len + 32'h1;
    end
  end
  flash_half_a:
    assert property (!display_lit_out |-> dark_len < FLASH_CNT) else $error("dark phase too long");
  ack_pulse_a:
    assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held past one cycle");
  ack_answer_a:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("request not answered");
  dat_quiet_a:
    assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
  item_onehot_a:
    assert property ($onehot(indicator_out)) else $error("indicator not one-hot");
  item_step_a:
    assert property ($changed(indicator_out) |-> indicator_out == $past(ind_rot)) else $error("item skipped");
  dir_glyph_a:
    assert property (indicator_out[4] |-> display_data_out == (reverse_out ? REVERSE_CODE : FORWARD_CODE))
      else $error("direction glyph wrong");
  dir_toggle_a:
    assert property ($changed(reverse_out) |-> indicator_out[4] && $changed(display_data_out))
      else $error("direction changed without display update");
  src_glyph_a:
    assert property (indicator_out[5] |-> display_data_out == (control_local_out ? LOCAL_CODE : REMOTE_CODE))
      else $error("control source glyph wrong");
  run_gate_a:
    assert property (run_command_out |-> !indicator_out[5] && !indicator_out[6]) else $error("run passed on gated item");
  flash_prog_a:
    assert property (!display_lit_out |-> indicator_out[6]) else $error("flash outside programming");
  rev_c: cover property ($rose(reverse_out));
  run_c: cover property ($rose(run_command_out));
  dark_c: cover property ($fell(display_lit_out));
endmodule
bind kmc_menu kmc_sva #(.CONFIRM_CNT(CONFIRM_CNT), .FLASH_CNT(FLASH_CNT)) chk (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .indicator_out(indicator_out),
  .display_data_out(display_data_out), .display_lit_out(display_lit_out), .reverse_out(reverse_out),
  .control_local_out(control_local_out), .run_command_out(run_command_out)
);

/* File: bench/kmc_operator.sv */
// operator model: one key press per request, held and then released
`timescale 1ns/1ns
module kmc_operator (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] press_in,
  output logic [3:0]      key_out,
  output logic            busy_out
);
  logic [3:0] held;
  logic [3:0] cnt;
  // four cycles down, at least five up: a key is always released before it is pressed again
  assign key_out  = (cnt > 4'h4) ? held : 4'h0;
  assign busy_out = (cnt != 4'h0);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      held <= 4'h0;
      cnt  <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (press_in != 4'h0) begin
      held <= press_in;
      cnt  <= 4'h8;
    end
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the keypad menu controller
`timescale 1ns/1ns
module tb;
  import kmc_pkg::*;
  localparam int unsigned CONF = 20;
  localparam logic [3:0] MODE = 4'h1, INC = 4'h2, DEC = 4'h4, ENT = 4'h8;
  logic        ref_clk_in, arst_n_in, busy, run_req, running, term_local;
  logic        cyc, stb, we, ack, lit, reverse_code, loc, run_cmd, saw_dark;
  logic [3:0]  press, keys;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, got;
  logic [6:0]  ind;
  logic [15:0] disp;
  int          bad_count, checks_done;
  kmc_menu #(.CONFIRM_CNT(CONF), .FLASH_CNT(4)) uut (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .key_mode_in(keys[0]), .key_inc_in(keys[1]),
    .key_dec_in(keys[2]), .key_enter_in(keys[3]), .run_request_in(run_req), .drive_running_in(running),
    .terminal_local_in(term_local), .monitor_value_in(16'h0042), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(4'hf), .wb_dat_out(rdat), .wb_ack_out(ack),
    .indicator_out(ind), .display_data_out(disp), .display_lit_out(lit), .reverse_out(reverse_code),
    .control_local_out(loc), .run_command_out(run_cmd));
  kmc_operator op (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .press_in(press), .key_out(keys),
    .busy_out(busy));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic push(input logic [3:0] k);
    @(posedge ref_clk_in);
    press <= k;
    @(posedge ref_clk_in);
    press <= 4'h0;
    cycles(2);
    while (busy) @(posedge ref_clk_in);
    cycles(1);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk_in);
    // only the watchdog bounds this wait
    while (ack !== 1'b1) @(posedge ref_clk_in);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    cycles(5000);
    bad_count++;
    complete_run;
  end
  initial begin
    {arst_n_in, press, run_req, running, term_local, cyc, stb, we, adr, wdat} = '0;
    cycles(3);
    check("reset item", 32'(ind), 32'h01);
    check("reset run", 32'(run_cmd), 32'h0);
    arst_n_in <= 1'b1;
    wb(1'b0, LOCK_MASK_ADR, 0);
    check("lock reset", got, 32'h0);
    wb(1'b1, LOCK_MASK_ADR, 32'h0002);
    wb(1'b0, LOCK_MASK_ADR, 0);
    check("lock rw", got, 32'h0002);
    wb(1'b1, 8'h20, 32'h5555);
    wb(1'b0, 8'h20, 0);
    check("unmapped", got, 32'h0);
    wb(1'b1, PARAM_SEL_ADR, 32'h1);
    wb(1'b1, PARAM_DATA_ADR, 32'h1234);
    push(MODE);
    check("monitor shown", 32'(disp), 32'h0042);
    repeat (3) push(MODE);
    check("dir item", 32'(ind), 32'h10);
    check("fwd glyph", 32'(disp), 32'(FORWARD_CODE));
    push(INC);
    check("reverse", 32'(reverse_code), 32'h1);
    wb(1'b0, STATUS_ADR, 0);
    check("status", got, (32'(direction_item) << ST_ITEM_LSB) | (32'h1 << ST_REVERSE_BIT));
    running <= 1'b1;
    push(DEC);
    check("dir running", 32'(reverse_code), 32'h0);
    push(MODE);
    push(INC);
    check("src running", 32'(disp), 32'(REMOTE_CODE));
    running <= 1'b0;
    push(INC);
    check("src local", 32'(disp), 32'(LOCAL_CODE));
    check("src out", 32'(loc), 32'h1);
    run_req <= 1'b1;
    cycles(4);
    check("run src", 32'(run_cmd), 32'h0);
    wb(1'b1, CONTROL_ADR, 32'h1);
    cycles(2);
    check("terminal takes", 32'(loc), 32'h0);
    push(INC);
    check("terminal", 32'(loc), 32'h0);
    term_local <= 1'b1;
    cycles(4);
    check("terminal follows", 32'(loc), 32'h1);
    wb(1'b1, CONTROL_ADR, 32'h0);
    push(MODE);
    push(INC);
    push(INC);
    push(DEC);
    check("pnum", 32'(disp), 32'({PNUM_PREFIX, 4'h1}));
    check("run prog", 32'(run_cmd), 32'h0);
    push(ENT);
    check("stored value", 32'(disp), 32'h1234);
    push(INC);
    saw_dark = 1'b0;
    repeat (12) begin
      @(posedge ref_clk_in);
      if (lit === 1'b0) saw_dark = 1'b1;
    end
    check("flash", 32'(saw_dark), 32'h1);
    push(ENT);
    check("confirm value", 32'(disp), 32'h1235);
    check("confirm lit", 32'(lit), 32'h1);
    cycles(CONF);
    check("back to number", 32'(disp), 32'({PNUM_PREFIX, 4'h1}));
    push(ENT);
    push(DEC);
    push(MODE);
    check("cancel", 32'(disp), 32'({PNUM_PREFIX, 4'h1}));
    wb(1'b0, PARAM_DATA_ADR, 0);
    check("kept value", got, 32'h1235);
    running <= 1'b1;
    push(ENT);
    push(INC);
    check("locked", 32'(disp), 32'h1235);
    push(MODE);
    running <= 1'b0;
    push(MODE);
    check("wrap", 32'(ind), 32'h01);
    check("still inhibited", 32'(run_cmd), 32'h0);
    run_req <= 1'b0;
    cycles(4);
    run_req <= 1'b1;
    cycles(4);
    check("rearmed", 32'(run_cmd), 32'h1);
    complete_run;
  end
endmodule
